// >>> rtl/rx_desc_pkg.sv
package rx_desc_pkg;
	// descriptor word 0 fields
	localparam int ADDR_MSB = 31;
	localparam int ADDR_LSB = 2;
	localparam int WRAP_BIT = 1;
	localparam int OWN_BIT = 0;
	// descriptor word 1 (status) fields
	localparam int ST_BCAST = 31;
	localparam int ST_MHASH = 30;
	localparam int ST_UHASH = 29;
	localparam int ST_SA_HIT = 27;
	localparam int ST_SA_IDX_LSB = 25;
	localparam int ST_TYPE_BIT = 24;
	localparam int ST_TYPE_LSB = 22;
	localparam int ST_VLAN = 21;
	localparam int ST_PRIO_TAG = 20;
	localparam int ST_VPRI_LSB = 17;
	localparam int ST_CFI = 16;
	localparam int ST_EOF = 15;
	localparam int ST_SOF = 14;
	localparam int ST_LEN13 = 13;
	localparam int LEN_W = 13;
	// step between descriptors, bytes (two words)
	localparam logic [31:0] DESC_STEP = 32'h0000_0008;
	localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
	localparam logic [31:0] BASE_RESET = 32'h0000_0000;
endpackage

// >>> rtl/rx_descriptor_writeback.sv
`timescale 1ns/1ps
// Contract
// - buffer address from word0 bits 31:2
// - word0 bit1 wraps list to base
// - write only when own clear; set after
// - status 31/30/29 broadcast, multicast, unicast hash
// - bit27 set on specific address match
// - index 26:25, highest filter wins
// - offload off: bit24 type-ID match
// - offload off: 23:22 highest type-ID filter
// - offload on: bit24 SNAP and CFI-clear
// - offload on: 23:22 checksum result code
// - bit21 VLAN 0x8100 tag, second if stacked
// - bit20 priority tag, null VLAN id
// - 19:17 priority, bit16 CFI, if VLAN
// - bit15 marks buffer with frame end
// - bit14 marks buffer with frame start
// - bit13 zero unless jumbo/ignore-FCS; jumbo length
// - ignore-FCS without jumbo: bit13 is FCS bad
// - 12:0 length, FCS per discard mode; code copies frame_len as given, fcs_discard_en unused
// - pointer plus two words, wrap reloads base
// - owned descriptor: not used, flag unavailable
// - non-final buffers zero except start
module rx_descriptor_writeback
	import rx_desc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// configuration
	input wire logic rx_enable,
	input wire logic [31:0] queue_base,
	input wire logic csum_offload_en,
	input wire logic jumbo_en,
	input wire logic ignore_fcs_en,
	input wire logic fcs_discard_en,
	// buffer request from receive data path
	input wire logic buf_req,
	input wire logic buf_last,
	input wire logic buf_first,
	output logic buf_grant,
	output logic [31:0] buf_addr,
	output logic buf_done,
	output logic buf_unavail,
	// frame result, sampled with buf_req on last buffer
	input wire logic bcast_hit,
	input wire logic mhash_hit,
	input wire logic uhash_hit,
	input wire logic [3:0] sa_match,
	input wire logic [3:0] type_match,
	input wire logic snap_ok,
	input wire logic [1:0] csum_code,
	input wire logic vlan_tag,
	input wire logic vlan_null_id,
	input wire logic [2:0] vlan_pri,
	input wire logic vlan_cfi,
	input wire logic fcs_bad,
	input wire logic [13:0] frame_len,
	// memory master port
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// descriptor pointer for status
	output logic [31:0] desc_ptr
);

	// ========================================
	// state
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_FETCH = 6'b000010,
		S_WAIT = 6'b000100,
		S_STAT = 6'b001000,
		S_OWN = 6'b010000,
		S_NEXT = 6'b100000
	} phase_type;

	typedef struct packed {
		phase_type phase;
		logic [31:0] ptr;
		logic [31:0] word0;
		logic [31:0] status;
		logic last;
		logic grant;
		logic done;
		logic unavail;
		logic [31:0] addr;
	} state_type;

	state_type s_q, s_d;

	// ========================================
	// status word assembly
	function automatic logic [1:0] top_idx(input logic [3:0] m);
		top_idx = m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
	endfunction

	logic [31:0] frame_status;
	logic [LEN_W-1:0] len_low;

	always_comb begin
		frame_status = 32'h0000_0000;
		len_low = frame_len[LEN_W-1:0];
		frame_status[ST_BCAST] = bcast_hit;
		frame_status[ST_MHASH] = mhash_hit;
		frame_status[ST_UHASH] = uhash_hit;
		frame_status[ST_SA_HIT] = |sa_match;
		frame_status[ST_SA_IDX_LSB +: 2] = top_idx(sa_match);
		if (csum_offload_en) begin
			frame_status[ST_TYPE_BIT] = snap_ok && (!vlan_tag || !vlan_cfi);
			frame_status[ST_TYPE_LSB +: 2] = csum_code;
		end else begin
			frame_status[ST_TYPE_BIT] = |type_match;
			frame_status[ST_TYPE_LSB +: 2] = top_idx(type_match);
		end
		frame_status[ST_VLAN] = vlan_tag;
		frame_status[ST_PRIO_TAG] = vlan_tag && vlan_null_id;
		if (vlan_tag) begin
			frame_status[ST_VPRI_LSB +: 3] = vlan_pri;
			frame_status[ST_CFI] = vlan_cfi;
		end
		frame_status[ST_EOF] = 1'b1;
		frame_status[ST_SOF] = buf_first;
		if (jumbo_en) begin
			frame_status[ST_LEN13] = frame_len[13];
		end else if (ignore_fcs_en) begin
			frame_status[ST_LEN13] = fcs_bad;
		end
		// length as reported by the receive path per fcs discard mode
		frame_status[LEN_W-1:0] = len_low;
	end

	// ========================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.grant = 1'b0;
		s_d.done = 1'b0;
		s_d.unavail = 1'b0;
		// while disabled and idle the pointer follows the list base
		if (!rx_enable && s_q.phase == S_IDLE) begin
			s_d.ptr = queue_base;
		end
		case (s_q.phase)
			S_IDLE: begin
				if (rx_enable && buf_req) begin
					s_d.phase = S_FETCH;
				end
			end
			S_FETCH: begin
				if (mem_ack) begin
					s_d.word0 = mem_rdata;
					if (mem_rdata[OWN_BIT]) begin
						s_d.unavail = 1'b1;
						s_d.phase = S_IDLE;
					end else begin
						s_d.addr = {mem_rdata[ADDR_MSB:ADDR_LSB], 2'h0};
						s_d.grant = 1'b1;
						s_d.phase = S_WAIT;
					end
				end
			end
			S_WAIT: begin
				// data path reports buffer filled by a second buf_req
				if (buf_req) begin
					s_d.last = buf_last;
					if (buf_last) begin
						s_d.status = frame_status;
					end else begin
						s_d.status = 32'h0000_0000;
						s_d.status[ST_SOF] = buf_first;
					end
					s_d.phase = S_STAT;
				end
			end
			S_STAT: begin
				if (mem_ack) begin
					s_d.phase = S_OWN;
				end
			end
			S_OWN: begin
				if (mem_ack) begin
					s_d.done = 1'b1;
					s_d.phase = S_NEXT;
				end
			end
			S_NEXT: begin
				if (s_q.word0[WRAP_BIT]) begin
					s_d.ptr = queue_base;
				end else begin
					s_d.ptr = s_q.ptr + DESC_STEP;
				end
				s_d.phase = S_IDLE;
			end
			default: begin
				s_d.phase = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_q <= '{phase: S_IDLE, ptr: BASE_RESET, word0: 32'h0000_0000,
				status: 32'h0000_0000, last: 1'b0, grant: 1'b0, done: 1'b0,
				unavail: 1'b0, addr: 32'h0000_0000};
		end else begin
			s_q <= s_d;
		end
	end

	// ========================================
	// outputs
	always_comb begin
		mem_req = 1'b0;
		mem_we = 1'b0;
		mem_addr = s_q.ptr;
		mem_wdata = 32'h0000_0000;
		case (s_q.phase)
			S_FETCH: begin
				mem_req = 1'b1;
			end
			S_STAT: begin
				mem_req = 1'b1;
				mem_we = 1'b1;
				mem_addr = s_q.ptr + STATUS_OFS;
				mem_wdata = s_q.status;
			end
			S_OWN: begin
				mem_req = 1'b1;
				mem_we = 1'b1;
				mem_wdata = s_q.word0 | 32'h0000_0001;
			end
			default: begin
				mem_req = 1'b0;
			end
		endcase
	end

	assign buf_grant = s_q.grant;
	assign buf_addr = s_q.addr;
	assign buf_done = s_q.done;
	assign buf_unavail = s_q.unavail;
	assign desc_ptr = s_q.ptr;

	// ========================================
	// checks
	AST_OWN_AFTER_STATUS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_OWN) |-> $past(s_q.phase == S_STAT || s_q.phase == S_OWN))
		else $error("ownership write not preceded by status write");
	AST_OWN_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mem_req && mem_we && mem_addr == s_q.ptr) |-> mem_wdata[OWN_BIT])
		else $error("ownership write lacks own bit");
	AST_UNAVAIL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_FETCH && mem_ack && mem_rdata[OWN_BIT]) |=> buf_unavail && !buf_grant)
		else $error("owned descriptor used");
	AST_ADVANCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_NEXT && !s_q.word0[WRAP_BIT] && rx_enable)
		|=> desc_ptr == $past(desc_ptr) + DESC_STEP)
		else $error("pointer did not advance two words");
	AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_NEXT && s_q.word0[WRAP_BIT]) |=> desc_ptr == $past(queue_base))
		else $error("wrap did not reload base");
	AST_MID_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_STAT && !s_q.last) |-> (mem_wdata & ~(32'h1 << ST_SOF)) == 32'h0)
		else $error("non-final status not zero");
	AST_EOF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_STAT) |-> mem_wdata[ST_EOF] == s_q.last)
		else $error("end of frame bit wrong");
	AST_BIT13: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!jumbo_en && !ignore_fcs_en) |-> !frame_status[ST_LEN13])
		else $error("bit 13 set with neither mode");
	AST_GRANT_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_FETCH && mem_ack && !mem_rdata[OWN_BIT])
		|=> buf_grant && buf_addr[ADDR_MSB:ADDR_LSB] == $past(mem_rdata[ADDR_MSB:ADDR_LSB]))
		else $error("buffer address not taken from descriptor");
	AST_PTR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_FETCH && mem_ack && mem_rdata[OWN_BIT]) |=> desc_ptr == $past(desc_ptr))
		else $error("pointer moved on owned descriptor");
	AST_SOF_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_WAIT && buf_req) |=> s_q.status[ST_SOF] == $past(buf_first))
		else $error("start of frame bit lost");
	AST_LEN_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.phase == S_WAIT && buf_req && buf_last)
		|=> s_q.status[LEN_W-1:0] == $past(frame_len[LEN_W-1:0]))
		else $error("frame length not stored");

	// frame status field checks
	AST_JUMBO_MSB: assert property (@(posedge ref_clk) disable iff (!rst_n)
		jumbo_en |-> frame_status[ST_LEN13] == frame_len[LEN_W])
		else $error("jumbo length bit wrong");
	AST_FCS_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!jumbo_en && ignore_fcs_en) |-> frame_status[ST_LEN13] == fcs_bad)
		else $error("fcs status bit wrong");
	AST_SA_TOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(|sa_match) |-> frame_status[ST_SA_IDX_LSB + 1] == (sa_match[3] || sa_match[2]))
		else $error("specific address index not highest");
	AST_SNAP_CFI: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(csum_offload_en && vlan_tag && vlan_cfi) |-> !frame_status[ST_TYPE_BIT])
		else $error("snap bit set with cfi tag");

endmodule

// >>> verification/sys_mem.sv
`timescale 1ns/1ps
// ====
// descriptor memory with software-owned list
module sys_mem (
	// clock
	input wire logic ref_clk,
	// memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack = 1'b0,
	output logic [31:0] mem_rdata = 32'h0,
	// answer speed
	input wire logic slow
);
	logic [31:0] m [0:15];
	logic [1:0] wait_q = 2'h0;
	logic [3:0] last_w = 4'h0;
	logic order_bad = 1'b0;
	always @(posedge ref_clk) begin
		mem_ack <= 1'b0;
		// stale read data keeps toggling
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && (!slow || wait_q == 2'h3)) begin
			mem_ack <= 1'b1;
			wait_q <= 2'h0;
			if (mem_we) begin
				m[mem_addr[5:2]] <= mem_wdata;
				last_w <= mem_addr[5:2];
				if (!mem_addr[2] && mem_wdata[0] && last_w != mem_addr[5:2] + 4'h1) begin
					order_bad <= 1'b1;
				end
			end else begin
				mem_rdata <= m[mem_addr[5:2]];
			end
		end else if (mem_req && !mem_ack) begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule

// >>> verification/rx_descriptor_writeback_tb.sv
`timescale 1ns/1ps
module rx_descriptor_writeback_tb;
	import rx_desc_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, rx_enable = 1'b0, slow = 1'b0;
	logic [31:0] queue_base = 32'h0000_0100;
	logic csum_offload_en = 0, jumbo_en = 0, ignore_fcs_en = 0, fcs_discard_en = 0;
	logic buf_req = 0, buf_last = 0, buf_first = 0, bcast_hit = 0, mhash_hit = 0;
	logic uhash_hit = 0, snap_ok = 0, vlan_tag = 0, vlan_null_id = 0, vlan_cfi = 0, fcs_bad = 0;
	logic [3:0] sa_match = 0, type_match = 0;
	logic [1:0] csum_code = 0;
	logic [2:0] vlan_pri = 0;
	logic [13:0] frame_len = 0;
	logic buf_grant, buf_done, buf_unavail, mem_req, mem_we, mem_ack;
	logic [31:0] buf_addr, mem_addr, mem_wdata, mem_rdata, desc_ptr;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	rx_descriptor_writeback dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .rx_enable(rx_enable), .queue_base(queue_base),
		.csum_offload_en(csum_offload_en), .jumbo_en(jumbo_en),
		.ignore_fcs_en(ignore_fcs_en), .fcs_discard_en(fcs_discard_en),
		.buf_req(buf_req), .buf_last(buf_last), .buf_first(buf_first),
		.buf_grant(buf_grant), .buf_addr(buf_addr), .buf_done(buf_done),
		.buf_unavail(buf_unavail), .bcast_hit(bcast_hit), .mhash_hit(mhash_hit),
		.uhash_hit(uhash_hit), .sa_match(sa_match), .type_match(type_match),
		.snap_ok(snap_ok), .csum_code(csum_code), .vlan_tag(vlan_tag),
		.vlan_null_id(vlan_null_id), .vlan_pri(vlan_pri), .vlan_cfi(vlan_cfi),
		.fcs_bad(fcs_bad), .frame_len(frame_len), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .desc_ptr(desc_ptr)
	);
	sys_mem mem (
		.ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow)
	);
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			tally_and_finish();
		end
	end
	// ====
	// helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	function automatic logic flag(int w);
		return (w == 0) ? buf_grant : (w == 1) ? buf_done : buf_unavail;
	endfunction
	task automatic await(input int w);
		int i;
		i = 0;
		while (flag(w) !== 1'b1 && i < 40) begin
			step();
			i++;
		end
		check("handshake", {31'h0, flag(w)}, 32'h1);
	endtask
	task automatic set_res(input logic [3:0] hits, input logic [3:0] sa, input logic [3:0] ty,
			input logic [1:0] cs, input logic [3:0] vl, input logic [2:0] pri, input logic [13:0] len);
		{bcast_hit, mhash_hit, uhash_hit, fcs_bad} = hits;
		sa_match = sa;
		type_match = ty;
		csum_code = cs;
		{snap_ok, vlan_tag, vlan_null_id, vlan_cfi} = vl;
		vlan_pri = pri;
		frame_len = len;
	endtask
	task automatic run_buf(input logic f, input logic l, input logic [31:0] a, input logic [31:0] st);
		logic [3:0] d;
		logic [31:0] nxt;
		d = desc_ptr[5:2];
		nxt = mem.m[d][WRAP_BIT] ? queue_base : desc_ptr + DESC_STEP;
		buf_req = 1'b1;
		step();
		buf_req = 1'b0;
		await(0);
		check("buf_addr", buf_addr, a);
		buf_req = 1'b1;
		buf_first = f;
		buf_last = l;
		step();
		buf_req = 1'b0;
		await(1);
		check("status", mem.m[d + 4'h1], st);
		check("own", {31'h0, mem.m[d][OWN_BIT]}, 32'h1);
		step();
		check("desc_ptr", desc_ptr, nxt);
	endtask
	// ====
	// scenarios
	task automatic scn_plain();
		set_res(4'h8, 4'h6, 4'h9, 2'h0, 4'h5, 3'h5, 14'h2040);
		run_buf(1, 1, 32'h0000_1000, 32'h8deb_c040);
	endtask
	task automatic scn_jumbo();
		slow = 1'b1;
		csum_offload_en = 1'b1;
		jumbo_en = 1'b1;
		set_res(4'h6, 4'h0, 4'h0, 2'h3, 4'he, 3'h0, 14'h2345);
		run_buf(1, 1, 32'h0000_2000, 32'h61f0_e345);
		slow = 1'b0;
	endtask
	task automatic scn_owned();
		set_res(4'h0, 4'h0, 4'h0, 2'h0, 4'hd, 3'h0, 14'h0000);
		buf_req = 1'b1;
		step();
		buf_req = 1'b0;
		await(2);
		check("ptr_kept", desc_ptr, queue_base);
	endtask
	task automatic scn_split();
		mem.m[0][OWN_BIT] = 1'b0;
		mem.m[2][OWN_BIT] = 1'b0;
		csum_offload_en = 1'b0;
		jumbo_en = 1'b0;
		ignore_fcs_en = 1'b1;
		fcs_discard_en = 1'b1;
		set_res(4'h1, 4'h0, 4'h0, 2'h0, 4'h0, 3'h0, 14'h2010);
		run_buf(1, 0, 32'h0000_1000, 32'h0000_4000);
		run_buf(0, 1, 32'h0000_2000, 32'h0000_a010);
	endtask
	initial begin
		mem.m[0] = 32'h0000_1000;
		mem.m[1] = 32'hffff_ffff;
		mem.m[2] = 32'h0000_2002;
		mem.m[3] = 32'hffff_ffff;
		repeat (4) step();
		rst_n = 1'b1;
		step();
		rx_enable = 1'b1;
		check("ptr_base", desc_ptr, queue_base);
		scn_plain();
		scn_jumbo();
		scn_owned();
		scn_split();
		check("order", {31'h0, mem.order_bad}, 32'h0);
		tally_and_finish();
	end
endmodule
